// [cmmbc_top.sv]
// Minimum-mode bus cycle sequencer, strobes, hold handshake and interrupt sampling
`timescale 1ns/1ps
module cmmbc_top
   import cmmbc_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clk_en,
   // Device pins in
   input wire logic maskable_irq_in,
   input wire logic nmi_in,
   input wire logic test_n_in,
   input wire logic hold_in,
   input wire logic ready_in,
   input wire logic reset_in,
   input wire logic bus_mode_select,
   // Core side
   input wire logic cyc_req,
   input wire cmmbc_kind_t cyc_kind,
   input wire logic instr_last,
   input wire logic irq_enable,
   input wire logic wait_instr,
   input wire logic [7:0] ack_type_in,
   // Device pins out
   output logic mem_io_o,
   output logic mem_io_oe_n,
   output logic wr_n_o,
   output logic wr_oe_n,
   output logic irq_ack_strobe_n,
   output logic ale_o,
   output logic bus_grant_ack,
   // Core status
   output logic cyc_done,
   output logic maskable_irq_in_take,
   output logic nmi_take,
   output logic [VEC_W-1:0] vector_addr,
   output logic wait_stall,
   output logic core_reset
);
   cmmbc_pins_if pins ();

   cmmbc_in_cond u_in_cond (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .pins_raw({bus_mode_select, reset_in, ready_in, hold_in, test_n_in, nmi_in,
         maskable_irq_in}),
      .pins(pins)
   );

   cmmbc_state_t state_q, state_d;
   cmmbc_kind_t kind_q, kind_d;
   logic mem_io_q, mem_io_d, float_q, float_d, wr_n_q, wr_n_d, irq_ack_strobe_n_n_q, irq_ack_strobe_n_n_d;
   logic ale_q, ale_d, grant_q, grant_d, done_q, done_d;
   logic nmi_pend_q, nmi_pend_d, maskable_irq_in_take_q, maskable_irq_in_take_d, nmi_take_q, nmi_take_d;
   logic [VEC_W-1:0] vec_q, vec_d;
   logic stall_q, stall_d, creset_q, creset_d;
   logic strobe_win, is_write;

   // Bus sequencer
   always_comb begin
      state_d = state_q;
      kind_d = kind_q;
      case (state_q)
         ST_IDLE: begin
            // grant only from idle or T4
            if (pins.hold_lvl) begin
               state_d = ST_HOLD;
            end else if (cyc_req) begin
               state_d = ST_LEAD;
               kind_d = cyc_kind;
            end
         end
         ST_LEAD: state_d = ST_T1;
         ST_T1: state_d = ST_T2;
         ST_T2: state_d = ST_T3;
         // wait states while ready is low
         ST_T3, ST_TW: state_d = pins.ready_lvl ? ST_T4 : ST_TW;
         ST_T4: begin
            if (pins.hold_lvl) begin
               state_d = ST_HOLD;
            end else if (cyc_req) begin
               state_d = ST_LEAD;
               kind_d = cyc_kind;
            end else begin
               state_d = ST_IDLE;
            end
         end
         ST_HOLD: state_d = pins.hold_lvl ? ST_HOLD : ST_IDLE;
         default: state_d = ST_IDLE;
      endcase
      // reset abandons whatever is in progress
      if (pins.reset_lvl) begin
         state_d = ST_IDLE;
         kind_d = KIND_MEM_RD;
      end
   end

   // Strobes computed from the next state so the pins come straight off flops
   always_comb begin
      strobe_win = (state_d == ST_T2) || (state_d == ST_T3) || (state_d == ST_TW);
      is_write = (kind_d == KIND_MEM_WR) || (kind_d == KIND_IO_WR);
      // latch enable only in T1, minimum mode only
      ale_d = pins.mode_min && (state_d == ST_T1);
      wr_n_d = !(pins.mode_min && strobe_win && is_write);
      irq_ack_strobe_n_n_d = !(pins.mode_min && strobe_win && (kind_d == KIND_IRQ_ACK_STROBE_N));
      grant_d = (state_d == ST_HOLD);
      float_d = grant_d;
      // status set entering the leading T4, held to the final T4
      mem_io_d = mem_io_q;
      if (state_d == ST_LEAD) begin
         mem_io_d = (kind_d == KIND_MEM_RD) || (kind_d == KIND_MEM_WR);
      end
      if (grant_d) begin
         mem_io_d = MEM_IO_FLOAT;
      end
      done_d = (state_d == ST_T4);
   end

   // Interrupt sampling, vectoring and wait stall
   always_comb begin
      // edge held pending; a new edge beats the clear
      nmi_pend_d = pins.nmi_edge | (nmi_pend_q & ~(instr_last & nmi_pend_q));
      // non-maskable wins and ignores the enable
      nmi_take_d = instr_last && nmi_pend_q;
      // sample only on the last clock
      maskable_irq_in_take_d = instr_last && !nmi_pend_q && pins.maskable_irq_in_lvl && irq_enable;
      vec_d = vec_q;
      // table entry is four bytes per type
      if (nmi_take_d) begin
         vec_d = {NMI_TYPE, 2'b00};
      end else if ((state_q == ST_T4) && (kind_q == KIND_IRQ_ACK_STROBE_N)) begin
         vec_d = {ack_type_in, 2'b00};
      end
      stall_d = wait_instr && !pins.test_low;
      creset_d = pins.reset_lvl;
      if (pins.reset_lvl) begin
         nmi_pend_d = 1'b0;
         nmi_take_d = 1'b0;
         maskable_irq_in_take_d = 1'b0;
         stall_d = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_IDLE;
         kind_q <= KIND_MEM_RD;
         mem_io_q <= MEM_IO_FLOAT;
         float_q <= 1'b0;
         wr_n_q <= 1'b1;
         irq_ack_strobe_n_n_q <= 1'b1;
         ale_q <= 1'b0;
         grant_q <= 1'b0;
         done_q <= 1'b0;
         nmi_pend_q <= 1'b0;
         nmi_take_q <= 1'b0;
         maskable_irq_in_take_q <= 1'b0;
         vec_q <= VEC_RESET;
         stall_q <= 1'b0;
         creset_q <= 1'b1;
      end else if (clk_en) begin
         state_q <= state_d;
         kind_q <= kind_d;
         mem_io_q <= mem_io_d;
         float_q <= float_d;
         wr_n_q <= wr_n_d;
         irq_ack_strobe_n_n_q <= irq_ack_strobe_n_n_d;
         ale_q <= ale_d;
         grant_q <= grant_d;
         done_q <= done_d;
         nmi_pend_q <= nmi_pend_d;
         nmi_take_q <= nmi_take_d;
         maskable_irq_in_take_q <= maskable_irq_in_take_d;
         vec_q <= vec_d;
         stall_q <= stall_d;
         creset_q <= creset_d;
      end
   end

   assign mem_io_o = mem_io_q;
   assign mem_io_oe_n = float_q;
   assign wr_n_o = wr_n_q;
   assign wr_oe_n = float_q;
   assign irq_ack_strobe_n = irq_ack_strobe_n_n_q;
   assign ale_o = ale_q;
   assign bus_grant_ack = grant_q;
   assign cyc_done = done_q;
   assign maskable_irq_in_take = maskable_irq_in_take_q;
   assign nmi_take = nmi_take_q;
   assign vector_addr = vec_q;
   assign wait_stall = stall_q;
   assign core_reset = creset_q;

   a_ale_t1_only: assert property (@(posedge clk_sys) disable iff (!rst_n)
      ale_o |-> (state_q == ST_T1) && !bus_grant_ack) else $error("ALE outside T1");
   a_ale_then_t2: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (ale_o && clk_en && !pins.reset_lvl) |=> (state_q == ST_T2))
      else $error("T1 not followed by T2");
   a_wr_window: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !wr_n_o |-> (state_q inside {ST_T2, ST_T3, ST_TW}) && kind_q inside {KIND_MEM_WR,
      KIND_IO_WR}) else $error("Write strobe outside its window");
   a_irq_ack_strobe_n_window: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !irq_ack_strobe_n |-> (state_q inside {ST_T2, ST_T3, ST_TW}) && kind_q == KIND_IRQ_ACK_STROBE_N)
      else $error("Ack strobe outside its window");
   a_grant_float: assert property (@(posedge clk_sys) disable iff (!rst_n)
      bus_grant_ack |-> mem_io_oe_n && wr_oe_n && mem_io_o && wr_n_o)
      else $error("Lines driven while granted");
   a_grant_entry: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $rose(bus_grant_ack) |-> $past(state_q) inside {ST_IDLE, ST_T4})
      else $error("Grant outside T4 or idle");
   a_wait_ready: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state_q == ST_TW && clk_en && !pins.ready_lvl && !pins.reset_lvl) |=> state_q == ST_TW)
      else $error("Left wait state without ready");
   a_mem_io_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state_q inside {ST_T1, ST_T2, ST_T3, ST_TW, ST_T4} && !$past(pins.reset_lvl))
      |-> $stable(mem_io_o)) else $error("Memory/IO select changed mid cycle");
   a_nmi_vector: assert property (@(posedge clk_sys) disable iff (!rst_n)
      nmi_take |-> vector_addr == {NMI_TYPE, 2'b00}) else $error("Wrong NMI vector");
   a_maskable_irq_in_masked: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (clk_en && !irq_enable) |=> !maskable_irq_in_take) else $error("Masked request taken");
   a_reset_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (clk_en && pins.reset_lvl) |=> state_q == ST_IDLE && wr_n_o && irq_ack_strobe_n)
      else $error("Cycle survived reset");
endmodule : cmmbc_top

// [cmmbc_pkg.sv]
// Shared constants and types for the minimum-mode bus control block
package cmmbc_pkg;
   // Bus cycle states; LEAD is the T4 that precedes T1 and carries the new status
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_LEAD = 3'b001,
      ST_T1 = 3'b010,
      ST_T2 = 3'b011,
      ST_T3 = 3'b100,
      ST_TW = 3'b101,
      ST_T4 = 3'b110,
      ST_HOLD = 3'b111
   } cmmbc_state_t;

   // Bus cycle kinds requested by the core
   typedef enum logic [2:0] {
      KIND_MEM_RD = 3'b000,
      KIND_MEM_WR = 3'b001,
      KIND_IO_RD = 3'b010,
      KIND_IO_WR = 3'b011,
      KIND_IRQ_ACK_STROBE_N = 3'b100
   } cmmbc_kind_t;

   localparam int unsigned SYNC_STAGES = 3;
   localparam int unsigned PIN_COUNT = 7;
   // Bit positions of the conditioned pins
   localparam int unsigned PIN_MASKABLE_IRQ_IN = 0;
   localparam int unsigned PIN_NMI = 1;
   localparam int unsigned PIN_TEST_N = 2;
   localparam int unsigned PIN_HOLD = 3;
   localparam int unsigned PIN_READY = 4;
   localparam int unsigned PIN_RESET = 5;
   localparam int unsigned PIN_MODE = 6;
   localparam logic [PIN_COUNT-1:0] PIN_RESET_VAL = 7'h24;
   localparam logic [7:0] NMI_TYPE = 8'h02;
   localparam int unsigned VEC_W = 10;
   localparam logic [VEC_W-1:0] VEC_RESET = 10'h000;
   localparam logic MEM_IO_FLOAT = 1'b1;
endpackage : cmmbc_pkg

// [cmmbc_pins_if.sv]
// Conditioned pin levels passed from the input stage to the bus controller
`timescale 1ns/1ps
interface cmmbc_pins_if;
   logic maskable_irq_in_lvl;
   logic nmi_edge;
   logic test_low;
   logic hold_lvl;
   logic ready_lvl;
   logic reset_lvl;
   logic mode_min;
   modport producer (output maskable_irq_in_lvl, nmi_edge, test_low, hold_lvl, ready_lvl, reset_lvl,
      mode_min);
   modport consumer (input maskable_irq_in_lvl, nmi_edge, test_low, hold_lvl, ready_lvl, reset_lvl,
      mode_min);
endinterface : cmmbc_pins_if

// [cmmbc_in_cond.sv]
// Three-stage pin synchronisers with agreement filter and NMI edge detect
`timescale 1ns/1ps
module cmmbc_in_cond
   import cmmbc_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clk_en,
   // Raw pins
   input wire logic [PIN_COUNT-1:0] pins_raw,
   // Conditioned levels
   cmmbc_pins_if.producer pins
);
   logic [PIN_COUNT-1:0] s1_q, s2_q, s3_q, lvl_q, lvl_d;
   logic nmi_edge_q, nmi_edge_d;

   genvar gi;
   generate
      for (gi = 0; gi < PIN_COUNT; gi++) begin : g_pin
         // A change counts only once stages two and three agree
         always_comb begin
            lvl_d[gi] = (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : lvl_q[gi];
         end
      end
   endgenerate

   always_comb begin
      nmi_edge_d = lvl_d[PIN_NMI] & ~lvl_q[PIN_NMI];
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= PIN_RESET_VAL;
         s2_q <= PIN_RESET_VAL;
         s3_q <= PIN_RESET_VAL;
         lvl_q <= PIN_RESET_VAL;
         nmi_edge_q <= 1'b0;
      end else if (clk_en) begin
         s1_q <= pins_raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
         lvl_q <= lvl_d;
         nmi_edge_q <= nmi_edge_d;
      end
   end

   assign pins.maskable_irq_in_lvl = lvl_q[PIN_MASKABLE_IRQ_IN];
   assign pins.nmi_edge = nmi_edge_q;
   // test sampled every clock on the rising edge
   assign pins.test_low = ~lvl_q[PIN_TEST_N];
   assign pins.hold_lvl = lvl_q[PIN_HOLD];
   assign pins.ready_lvl = lvl_q[PIN_READY];
   assign pins.reset_lvl = lvl_q[PIN_RESET];
   assign pins.mode_min = lvl_q[PIN_MODE];
endmodule : cmmbc_in_cond

// [cmmbc_far_model.sv]
// Behavioural memory, I/O and acknowledge responder for the bus control bench
`timescale 1ns/1ps
module cmmbc_far_model (
   // Clock and reset
   clk_sys,
   rst_n,
   // Bus strobes seen
   ale_o,
   cyc_done,
   // Bench controls
   stall_cycles,
   type_sel,
   // Answers
   ready_in,
   ack_type_in
);
   input wire logic clk_sys;
   input wire logic rst_n;
   input wire logic ale_o;
   input wire logic cyc_done;
   input wire logic [3:0] stall_cycles;
   input wire logic [7:0] type_sel;
   output logic ready_in;
   output logic [7:0] ack_type_in;

   logic [3:0] cnt_q;
   logic run_q;
   // slow answer: ready idles low from the previous T4 on when a stall is asked
   // because the design sees the pin only four edges later, after its T3 decision
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 4'h0;
         run_q <= 1'b0;
      end else if (ale_o) begin
         cnt_q <= stall_cycles;
         run_q <= 1'b1;
      end else if (cyc_done) begin
         run_q <= 1'b0;
      end else if (cnt_q != 4'h0) begin
         cnt_q <= cnt_q - 4'h1;
      end
   end
   assign ready_in = (stall_cycles == 4'h0) || (run_q && !cyc_done && cnt_q == 4'h0);
   // Type byte is only valid in T4; otherwise show its inverse so stale data is caught
   assign ack_type_in = cyc_done ? type_sel : ~type_sel;
endmodule : cmmbc_far_model

// [tb_top.sv]
// Self-checking bench for the minimum-mode bus control block
`timescale 1ns/1ps
module tb_top;
   import cmmbc_pkg::*;
   logic clk_sys = 1'b0, rst_n = 1'b0, clk_en = 1'b1, maskable_irq_in = 1'b0, nmi_in = 1'b0;
   logic test_n_in = 1'b1, hold_in = 1'b0, reset_in = 1'b0, bus_mode_select = 1'b1;
   logic cyc_req = 1'b0, instr_last = 1'b0, irq_enable = 1'b0, wait_instr = 1'b0, ready_in;
   logic [3:0] stall = 4'h0;
   logic [7:0] type_sel = 8'h00, ack_type_in;
   cmmbc_kind_t cyc_kind = KIND_MEM_RD;
   logic mem_io_o, mem_io_oe_n, wr_n_o, wr_oe_n, irq_ack_strobe_n, ale_o, bus_grant_ack;
   logic cyc_done, maskable_irq_in_take, nmi_take, wait_stall, core_reset;
   logic [VEC_W-1:0] vector_addr;
   logic [31:0] seed = 32'h0000DD89;
   int miscompares = 0, num_checks = 0, n, wlo, alo, cur, mode_min = 1, in_cyc = 0, vchk = 0;
   int q[$];

   cmmbc_top u_cmmbc_top (
      .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .maskable_irq_in(maskable_irq_in),
      .nmi_in(nmi_in), .test_n_in(test_n_in), .hold_in(hold_in), .ready_in(ready_in),
      .reset_in(reset_in), .bus_mode_select(bus_mode_select), .cyc_req(cyc_req),
      .cyc_kind(cyc_kind), .instr_last(instr_last), .irq_enable(irq_enable),
      .wait_instr(wait_instr), .ack_type_in(ack_type_in), .mem_io_o(mem_io_o),
      .mem_io_oe_n(mem_io_oe_n), .wr_n_o(wr_n_o), .wr_oe_n(wr_oe_n),
      .irq_ack_strobe_n(irq_ack_strobe_n), .ale_o(ale_o), .bus_grant_ack(bus_grant_ack),
      .cyc_done(cyc_done), .maskable_irq_in_take(maskable_irq_in_take), .nmi_take(nmi_take),
      .vector_addr(vector_addr), .wait_stall(wait_stall), .core_reset(core_reset));
   cmmbc_far_model u_cmmbc_far_model (
      .clk_sys(clk_sys), .rst_n(rst_n), .ale_o(ale_o), .cyc_done(cyc_done),
      .stall_cycles(stall), .type_sel(type_sel), .ready_in(ready_in),
      .ack_type_in(ack_type_in));

   // only rising edges are used, so an even clock stands in for the asymmetric one
   always #20 clk_sys = ~clk_sys;

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   function automatic logic sig(input int sel);
      case (sel)
         0: return cyc_done;
         1: return bus_grant_ack;
         2: return core_reset;
         default: return wr_n_o;
      endcase
   endfunction : sig

   task automatic check(input logic ok, input string msg);
      num_checks++;
      if (ok !== 1'b1) begin
         miscompares++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask : check

   task automatic end_of_test();
      $display("checks %0d, miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_of_test

   task automatic await(input int sel, input logic lvl);
      for (int i = 0; i < 60; i++) begin
         @(negedge clk_sys);
         if (sig(sel) === lvl) return;
      end
      miscompares++;
      $display("mismatch at %0t: timeout", $time);
      end_of_test();
   endtask : await

   // Expected cycle goes on the queue as kind*16 + stall
   task automatic start_cyc(input cmmbc_kind_t k, input logic [3:0] s);
      cyc_req <= 1'b1;
      cyc_kind <= k;
      stall <= s;
      if (mode_min != 0) q.push_back(int'(k) * 16 + int'(s));
   endtask : start_cyc

   task automatic pulse_last();
      @(posedge clk_sys);
      instr_last <= 1'b1;
      @(posedge clk_sys);
      instr_last <= 1'b0;
      @(negedge clk_sys);
   endtask : pulse_last

   // Reference model of every minimum-mode bus cycle, judged at T1 and at T4
   always @(negedge clk_sys) begin
      if (vchk != 0) check(vector_addr === {type_sel, 2'b00}, "vector");
      vchk = 0;
      if (mode_min == 0) begin
         check(ale_o === 1'b0 && wr_n_o === 1'b1 && irq_ack_strobe_n === 1'b1, "max mode");
      end else if (ale_o === 1'b1 && in_cyc == 0) begin
         check(q.size() > 0, "unexpected cycle");
         if (q.size() > 0) cur = q.pop_front();
         check(mem_io_o === (cur / 16 < 2), "mem io at T1");
         in_cyc = 1;
         n = 0;
         wlo = 0;
         alo = 0;
      end else if (in_cyc != 0 && cyc_done === 1'b1) begin
         check(n >= 2 && (n == 2) == (cur % 16 == 0), "state count");
         check(wlo == ((cur / 16 == 1 || cur / 16 == 3) ? n : 0), "write strobe");
         check(alo == (cur / 16 == 4 ? n : 0), "ack strobe");
         check(mem_io_o === (cur / 16 < 2), "mem io at T4");
         vchk = (cur / 16 == 4);
         in_cyc = 0;
      end else if (in_cyc != 0) begin
         check(ale_o === 1'b0, "ale width");
         n++;
         wlo += (wr_n_o === 1'b0);
         alo += (irq_ack_strobe_n === 1'b0);
      end
   end

   initial begin
      repeat (12) @(posedge clk_sys);
      rst_n <= 1'b1;
      await(2, 1'b0);
      @(posedge clk_sys);
      type_sel <= 8'(rnd());
      start_cyc(cmmbc_kind_t'(3'(rnd() % 5)), 4'h0);
      // Back-to-back random cycles, about half of them stretched by the far side
      for (int i = 0; i < 14; i++) begin
         await(0, 1'b1);
         if (i < 13) start_cyc(cmmbc_kind_t'(3'(rnd() % 5)), (rnd() % 2) ? 4'h8 : 4'h0);
         else cyc_req <= 1'b0;
      end
      hold_in <= 1'b1;
      await(1, 1'b1);
      check(mem_io_o === 1'b1 && mem_io_oe_n === 1'b1 && wr_oe_n === 1'b1, "float");
      check(wr_n_o === 1'b1 && irq_ack_strobe_n === 1'b1 && ale_o === 1'b0, "idle");
      @(posedge clk_sys);
      start_cyc(KIND_IO_WR, 4'h0);
      repeat (10) @(posedge clk_sys);
      check(bus_grant_ack === 1'b1 && q.size() == 1, "held off");
      hold_in <= 1'b0;
      await(0, 1'b1);
      cyc_req <= 1'b0;
      check(mem_io_oe_n === 1'b0 && bus_grant_ack === 1'b0, "driven again");
      maskable_irq_in <= 1'b1;
      repeat (6) @(negedge clk_sys);
      pulse_last();
      check(maskable_irq_in_take === 1'b0, "masked");
      irq_enable <= 1'b1;
      repeat (6) @(negedge clk_sys);
      check(maskable_irq_in_take === 1'b0, "not last clock");
      pulse_last();
      check(maskable_irq_in_take === 1'b1, "taken");
      irq_enable <= 1'b0;
      nmi_in <= 1'b1;
      repeat (6) @(negedge clk_sys);
      pulse_last();
      check(nmi_take === 1'b1 && vector_addr === {NMI_TYPE, 2'b00}, "nmi");
      pulse_last();
      check(nmi_take === 1'b0 && maskable_irq_in_take === 1'b0, "nmi once");
      wait_instr <= 1'b1;
      repeat (8) @(negedge clk_sys);
      check(wait_stall === 1'b1, "stall");
      test_n_in <= 1'b0;
      repeat (8) @(negedge clk_sys);
      check(wait_stall === 1'b0, "proceed");
      @(posedge clk_sys);
      start_cyc(KIND_MEM_WR, 4'h8);
      await(3, 1'b0);
      reset_in <= 1'b1;
      cyc_req <= 1'b0;
      await(2, 1'b1);
      check(wr_n_o === 1'b1 && ale_o === 1'b0, "abandoned");
      @(posedge clk_sys);
      in_cyc = 0;
      q.delete();
      repeat (6) @(negedge clk_sys);
      reset_in <= 1'b0;
      await(2, 1'b0);
      bus_mode_select <= 1'b0;
      repeat (8) @(posedge clk_sys);
      mode_min = 0;
      start_cyc(KIND_MEM_WR, 4'h0);
      await(0, 1'b1);
      cyc_req <= 1'b0;
      repeat (4) @(negedge clk_sys);
      end_of_test();
   end
endmodule : tb_top
